// file: rtl/lptc_params.svh
// Constants of the low power tick counter: offsets, field positions, limits
`ifndef LPTC_PARAMS_SVH
`define LPTC_PARAMS_SVH

// Bus geometry
`define LPTC_ADDR_W       12
`define LPTC_DATA_W       32
`define LPTC_STRB_W       4
`define LPTC_CNT_W        24
`define LPTC_NFLAG        3

// Register byte offsets
`define LPTC_OFF_CTRL     12'h000
`define LPTC_OFF_CNT      12'h004
`define LPTC_OFF_MATCH0   12'h008
`define LPTC_OFF_MATCH1   12'h00c
`define LPTC_OFF_FLAGS    12'h010
`define LPTC_OFF_FSET     12'h014
`define LPTC_OFF_FCLR     12'h018
`define LPTC_OFF_IEN      12'h01c
`define LPTC_OFF_HOLD     12'h020
`define LPTC_OFF_PEND     12'h024

// Control field positions
`define LPTC_CTRL_EN      0
`define LPTC_CTRL_RUNH    1
`define LPTC_CTRL_TOP     2

// Flag field positions, shared by flags, set, clear and enable registers
`define LPTC_FLG_WRAP     0
`define LPTC_FLG_M0       1
`define LPTC_FLG_M1       2

// Pending-transfer field positions
`define LPTC_PND_CTRL     0
`define LPTC_PND_M0       1
`define LPTC_PND_M1       2

// Limits and reset values
`define LPTC_CNT_MAX      24'hffffff
`define LPTC_CNT_RST      24'h000000
`define LPTC_CNT_ONE      24'h000001
`define LPTC_RESP_OKAY    2'h0
`define LPTC_RESP_SLVERR  2'h2
`define LPTC_WORD_LSB     2'h0

`endif

// file: rtl/lptc_pkg.sv
// State types of the low power tick counter
`default_nettype none
`include "lptc_params.svh"

package lptc_pkg;

  // Pin synchroniser state
  typedef struct packed {
    logic s1;   // First stage, read only by the second
    logic s2;   // Second stage
    logic s3;   // Third stage
    logic lvl;  // Filtered level
  } lptc_sync_type;

  // Compare channel state
  typedef struct packed {
    logic pulse;  // Event network pulse, one counter cycle
    logic start;  // Timer start, one bus cycle
  } lptc_chan_type;

  // Top level state
  typedef struct packed {
    logic [2:0]                  ctrl_sh;   // Control as written
    logic [2:0]                  ctrl_act;  // Control as used by the counter
    logic [`LPTC_CNT_W-1:0]      m0_sh;
    logic [`LPTC_CNT_W-1:0]      m0_act;
    logic [`LPTC_CNT_W-1:0]      m1_sh;
    logic [`LPTC_CNT_W-1:0]      m1_act;
    logic [2:0]                  pend;      // Transfers not yet taken over
    logic [`LPTC_CNT_W-1:0]      cnt;
    logic [`LPTC_NFLAG-1:0]      flags;
    logic [`LPTC_NFLAG-1:0]      ien;
    logic                        hold;
    logic                        tick_prev;
    logic                        aw_held;
    logic [`LPTC_ADDR_W-1:0]     aw_addr;
    logic                        w_held;
    logic [`LPTC_DATA_W-1:0]     w_data;
    logic [`LPTC_STRB_W-1:0]     w_strb;
    logic                        awready;
    logic                        wready;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [1:0]                  rresp;
    logic [`LPTC_DATA_W-1:0]     rdata;
    logic                        irq;
  } lptc_top_type;

endpackage : lptc_pkg

`default_nettype wire

// file: rtl/lptc_pin_sync.sv
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/10ps
`default_nettype none

module lptc_pin_sync (
  input  wire logic i_clock,  // Bus clock
  input  wire logic i_nrst,   // Asynchronous reset, active low
  input  wire logic i_pin,    // Asynchronous input
  output var  logic o_level   // Filtered level
);

  lptc_pkg::lptc_sync_type st_q;  // Registered state
  lptc_pkg::lptc_sync_type st_d;  // Next state

  // Shift chain; the level follows only once two late stages agree
  always_comb begin
    st_d     = st_q;
    st_d.s1  = i_pin;
    st_d.s2  = st_q.s1;
    st_d.s3  = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s3;
    end
  end

  // State register
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_level = st_q.lvl;

endmodule : lptc_pin_sync

`default_nettype wire

// file: rtl/lptc_match_chan.sv
// One compare channel: match detect, event pulse and timer start
`timescale 1ns/10ps
`default_nettype none
`include "lptc_params.svh"

module lptc_match_chan #(
  parameter int W = `LPTC_CNT_W  // Count width
) (
  input  wire logic         i_clock,  // Bus clock
  input  wire logic         i_nrst,   // Asynchronous reset, active low
  input  wire logic         i_tick,   // Counter tick, one cycle
  input  wire logic         i_run,    // Counter advances this cycle
  input  wire logic [W-1:0] i_count,  // Current count
  input  wire logic [W-1:0] i_value,  // Compare value in use
  output logic              o_hit,    // Match this cycle
  output var  logic         o_pulse,  // Event network pulse
  output var  logic         o_start   // Timer start pulse
);

  lptc_pkg::lptc_chan_type st_q;  // Registered state
  lptc_pkg::lptc_chan_type st_d;  // Next state

  // A match only counts on a tick that advances the counter
  assign o_hit = i_run && (i_count == i_value);

  // Pulse spans one counter period: set on the match, dropped on the next tick
  always_comb begin
    st_d       = st_q;
    st_d.start = o_hit;
    if (o_hit) begin
      st_d.pulse = 1'b1;
    end else if (i_tick) begin
      st_d.pulse = 1'b0;
    end
  end

  // State register
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_pulse = st_q.pulse;
  assign o_start = st_q.start;

endmodule : lptc_match_chan

`default_nettype wire

// file: rtl/lptc_top.sv
// Low power tick counter: AXI4-Lite registers, counter, two compare channels
`timescale 1ns/10ps
`default_nettype none
`include "lptc_params.svh"

module lptc_top (
  input  wire logic                     i_clock,       // Bus clock, 125 MHz
  input  wire logic                     i_nrst,        // Asynchronous reset, active low
  input  wire logic                     i_lf_tick,     // Prescaled low frequency clock pin
  input  wire logic                     i_debug_halt,  // Debugger halt, same clock
  input  wire logic                     i_awvalid,
  output var  logic                     o_awready,
  input  wire logic [`LPTC_ADDR_W-1:0]  i_awaddr,
  input  wire logic                     i_wvalid,
  output var  logic                     o_wready,
  input  wire logic [`LPTC_DATA_W-1:0]  i_wdata,
  input  wire logic [`LPTC_STRB_W-1:0]  i_wstrb,
  output var  logic                     o_bvalid,
  input  wire logic                     i_bready,
  output var  logic [1:0]               o_bresp,
  input  wire logic                     i_arvalid,
  output var  logic                     o_arready,
  input  wire logic [`LPTC_ADDR_W-1:0]  i_araddr,
  output var  logic                     o_rvalid,
  input  wire logic                     i_rready,
  output var  logic [`LPTC_DATA_W-1:0]  o_rdata,
  output var  logic [1:0]               o_rresp,
  output var  logic                     o_irq,         // Level interrupt
  output var  logic [1:0]               o_match_pulse, // Event network pulses
  output var  logic [1:0]               o_timer_start  // Timer start pulses
);

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);

  lptc_pkg::lptc_top_type st_q;  // Registered state
  lptc_pkg::lptc_top_type st_d;  // Next state

  logic                    lf_level;  // Filtered low frequency clock
  logic                    tick;      // One cycle per counter clock edge
  logic                    load;      // Pending values are taken over now
  logic [2:0]              ctrl_eff;  // Control in force this tick
  logic [`LPTC_CNT_W-1:0]  m0_eff;    // Match zero in force this tick
  logic [`LPTC_CNT_W-1:0]  m1_eff;    // Match one in force this tick
  logic [`LPTC_CNT_W-1:0]  top;       // Value at which the count returns to zero
  logic                    run;       // Counter advances this cycle
  logic                    hit0;      // Match on channel zero
  logic                    hit1;      // Match on channel one
  logic                    do_wr;     // Write executes this cycle
  logic [`LPTC_DATA_W-1:0] wmask;     // Byte lanes of the write

  // Pin from the low frequency domain is filtered before use
  lptc_pin_sync u_tick_sync (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_pin   (i_lf_tick),
    .o_level (lf_level)
  );

  // Rising edge of the filtered level is the counter clock edge
  assign tick = lf_level && !st_q.tick_prev;

  // Freeze holds new settings back so several can land on one tick
  assign load = tick && !st_q.hold;
  // Settings written since the last tick take effect on this one
  always_comb begin
    ctrl_eff = (load && st_q.pend[`LPTC_PND_CTRL]) ? st_q.ctrl_sh : st_q.ctrl_act;
    m0_eff   = (load && st_q.pend[`LPTC_PND_M0]) ? st_q.m0_sh : st_q.m0_act;
    m1_eff   = (load && st_q.pend[`LPTC_PND_M1]) ? st_q.m1_sh : st_q.m1_act;
  end

  // Counting gate: enabled, and not frozen by a halted debugger
  assign run = tick && ctrl_eff[`LPTC_CTRL_EN]
               && (!i_debug_halt || ctrl_eff[`LPTC_CTRL_RUNH]);

  // Top value selection
  assign top = ctrl_eff[`LPTC_CTRL_TOP] ? m0_eff : `LPTC_CNT_MAX;

  // Compare channel zero
  lptc_match_chan #(
    .W (`LPTC_CNT_W)
  ) u_chan0 (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_tick  (tick),
    .i_run   (run),
    .i_count (st_q.cnt),
    .i_value (m0_eff),
    .o_hit   (hit0),
    .o_pulse (o_match_pulse[0]),
    .o_start (o_timer_start[0])
  );

  // Compare channel one
  lptc_match_chan #(
    .W (`LPTC_CNT_W)
  ) u_chan1 (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_tick  (tick),
    .i_run   (run),
    .i_count (st_q.cnt),
    .i_value (m1_eff),
    .o_hit   (hit1),
    .o_pulse (o_match_pulse[1]),
    .o_start (o_timer_start[1])
  );

  // A write runs once both address and data are held and no response waits
  assign do_wr = st_q.aw_held && st_q.w_held && !st_q.bvalid;

  // Byte lanes expanded to bits
  always_comb begin
    for (int i = 0; i < `LPTC_STRB_W; i++) begin
      wmask[i*8 +: 8] = {8{st_q.w_strb[i]}};
    end
  end

  // Merge written lanes into an old value
  function automatic logic [`LPTC_DATA_W-1:0] lptc_merge(
    input logic [`LPTC_DATA_W-1:0] old_v,
    input logic [`LPTC_DATA_W-1:0] new_v,
    input logic [`LPTC_DATA_W-1:0] mask
  );
    lptc_merge = (old_v & ~mask) | (new_v & mask);
  endfunction : lptc_merge

  // Whole next-state computation
  always_comb begin
    logic [`LPTC_DATA_W-1:0]  wbits;   // Written data within lanes
    logic [`LPTC_DATA_W-1:0]  rd;      // Read data before registering
    logic                     rd_ok;   // Read address is mapped
    logic                     wr_ok;   // Write address is mapped
    logic [`LPTC_NFLAG-1:0]   f_set;   // Flags set this cycle
    logic [`LPTC_NFLAG-1:0]   f_clr;   // Flags cleared this cycle
    logic [2:0]               p_new;   // Transfers started this cycle
    wbits = st_q.w_data & wmask;
    rd    = '0;
    rd_ok = 1'b1;
    wr_ok = 1'b1;
    f_set = '0;
    f_clr = '0;
    p_new = '0;
    st_d  = st_q;
    st_d.tick_prev = lf_level;

    // Take over settings at the tick and retire their busy bits
    if (load) begin
      st_d.ctrl_act = ctrl_eff;
      st_d.m0_act   = m0_eff;
      st_d.m1_act   = m1_eff;
      st_d.pend     = '0;
    end

    // Counter update
    if (tick && !ctrl_eff[`LPTC_CTRL_EN]) begin
      st_d.cnt = `LPTC_CNT_RST;
    end else if (run && (st_q.cnt == top)) begin
      st_d.cnt = `LPTC_CNT_RST;
      f_set[`LPTC_FLG_WRAP] = 1'b1;
    end else if (run) begin
      st_d.cnt = st_q.cnt + `LPTC_CNT_ONE;
    end

    // Match flags
    f_set[`LPTC_FLG_M0] = hit0;
    f_set[`LPTC_FLG_M1] = hit1;

    // Write address channel
    if (i_awvalid && st_q.awready) begin
      st_d.aw_held = 1'b1;
      st_d.aw_addr = i_awaddr;
    end
    // Write data channel
    if (i_wvalid && st_q.wready) begin
      st_d.w_held = 1'b1;
      st_d.w_data = i_wdata;
      st_d.w_strb = i_wstrb;
    end

    // Write execution; only the defined low bits are kept
    if (do_wr) begin
      unique case ({st_q.aw_addr[`LPTC_ADDR_W-1:2], `LPTC_WORD_LSB})
        `LPTC_OFF_CTRL: begin
          st_d.ctrl_sh = 3'(lptc_merge({29'h0, st_q.ctrl_sh}, st_q.w_data, wmask));
          p_new[`LPTC_PND_CTRL] = 1'b1;
        end
        `LPTC_OFF_MATCH0: begin
          st_d.m0_sh = (`LPTC_CNT_W)'(lptc_merge({8'h0, st_q.m0_sh}, st_q.w_data, wmask));
          p_new[`LPTC_PND_M0] = 1'b1;
        end
        `LPTC_OFF_MATCH1: begin
          st_d.m1_sh = (`LPTC_CNT_W)'(lptc_merge({8'h0, st_q.m1_sh}, st_q.w_data, wmask));
          p_new[`LPTC_PND_M1] = 1'b1;
        end
        `LPTC_OFF_FSET: begin
          f_set = f_set | wbits[`LPTC_NFLAG-1:0];
        end
        `LPTC_OFF_FCLR: begin
          f_clr = wbits[`LPTC_NFLAG-1:0];
        end
        `LPTC_OFF_IEN: begin
          st_d.ien = (`LPTC_NFLAG)'(lptc_merge({29'h0, st_q.ien}, st_q.w_data, wmask));
        end
        `LPTC_OFF_HOLD: begin
          st_d.hold = 1'(lptc_merge({31'h0, st_q.hold}, st_q.w_data, wmask));
        end
        // Count, flags and busy bits are read only; writes there are dropped
        `LPTC_OFF_CNT, `LPTC_OFF_FLAGS, `LPTC_OFF_PEND: begin
          wr_ok = 1'b1;
        end
        default: begin
          wr_ok = 1'b0;
        end
      endcase
      st_d.aw_held = 1'b0;
      st_d.w_held  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = wr_ok ? `LPTC_RESP_OKAY : `LPTC_RESP_SLVERR;
    end else if (st_q.bvalid && i_bready) begin
      st_d.bvalid = 1'b0;
    end

    // Busy bits: a fresh write keeps its bit set across a same-cycle take-over
    st_d.pend = st_d.pend | p_new;

    // Flags: hardware or software set wins over a clear in the same cycle
    st_d.flags = (st_q.flags & ~f_clr) | f_set;

    // Read channel
    if (i_arvalid && st_q.arready) begin
      unique case ({i_araddr[`LPTC_ADDR_W-1:2], `LPTC_WORD_LSB})
        `LPTC_OFF_CTRL:   rd[2:0] = st_q.ctrl_sh;
        `LPTC_OFF_CNT:    rd[`LPTC_CNT_W-1:0] = st_q.cnt;
        `LPTC_OFF_MATCH0: rd[`LPTC_CNT_W-1:0] = st_q.m0_sh;
        `LPTC_OFF_MATCH1: rd[`LPTC_CNT_W-1:0] = st_q.m1_sh;
        `LPTC_OFF_FLAGS:  rd[`LPTC_NFLAG-1:0] = st_q.flags;
        `LPTC_OFF_FSET,
        `LPTC_OFF_FCLR:   rd = '0;
        `LPTC_OFF_IEN:    rd[`LPTC_NFLAG-1:0] = st_q.ien;
        `LPTC_OFF_HOLD:   rd[0] = st_q.hold;
        `LPTC_OFF_PEND:   rd[2:0] = st_q.pend;
        default:          rd_ok = 1'b0;
      endcase
      st_d.rvalid = 1'b1;
      st_d.rdata  = rd;
      st_d.rresp  = rd_ok ? `LPTC_RESP_OKAY : `LPTC_RESP_SLVERR;
    end else if (st_q.rvalid && i_rready) begin
      st_d.rvalid = 1'b0;
    end

    // Ready flags: one transaction per direction in flight
    st_d.awready = !st_d.aw_held && !st_d.bvalid;
    st_d.wready  = !st_d.w_held && !st_d.bvalid;
    st_d.arready = !st_d.rvalid;

    // Interrupt from the next flag and enable values, so it is a flop output
    st_d.irq = |(st_d.flags & st_d.ien);
  end

  // State register; everything resets to zero, count included
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign o_awready = st_q.awready;
  assign o_wready  = st_q.wready;
  assign o_bvalid  = st_q.bvalid;
  assign o_bresp   = st_q.bresp;
  assign o_arready = st_q.arready;
  assign o_rvalid  = st_q.rvalid;
  assign o_rdata   = st_q.rdata;
  assign o_rresp   = st_q.rresp;
  assign o_irq     = st_q.irq;

  // Named steps of a control write reaching the counter
  sequence s_ctrl_write;
    do_wr && ({st_q.aw_addr[`LPTC_ADDR_W-1:2], `LPTC_WORD_LSB} == `LPTC_OFF_CTRL);
  endsequence
  sequence s_takeover;
    load && st_q.pend[`LPTC_PND_CTRL];
  endsequence

  // Disabled tick clears the count
  AST_CLEAR_ON_DISABLE: assert property (
    (tick && !ctrl_eff[`LPTC_CTRL_EN]) |=> (st_q.cnt == `LPTC_CNT_RST))
    else $error("count not cleared while disabled");

  // Count only moves on a tick
  AST_COUNT_HOLDS: assert property (
    !tick |=> $stable(st_q.cnt))
    else $error("count moved without a tick");

  // Step of one below the top
  AST_COUNT_STEP: assert property (
    (run && (st_q.cnt != top)) |=> (st_q.cnt == $past(st_q.cnt) + `LPTC_CNT_ONE))
    else $error("count did not step by one");

  // Top mode clears after a match on channel zero
  AST_TOP_MATCH0: assert property (
    (run && ctrl_eff[`LPTC_CTRL_TOP] && hit0) |=> (st_q.cnt == `LPTC_CNT_RST))
    else $error("count not cleared after top match");

  // Full wrap sets the wrap flag
  AST_WRAP_FULL: assert property (
    (run && !ctrl_eff[`LPTC_CTRL_TOP] && (st_q.cnt == `LPTC_CNT_MAX))
    |=> (st_q.cnt == `LPTC_CNT_RST) && st_q.flags[`LPTC_FLG_WRAP])
    else $error("full wrap wrong");

  // Halted debugger freezes the count unless allowed to run
  AST_HALT_FREEZE: assert property (
    (tick && i_debug_halt && !ctrl_eff[`LPTC_CTRL_RUNH]) |=> $stable(st_q.cnt)
      or (st_q.cnt == `LPTC_CNT_RST))
    else $error("count moved under halt");

  // Channel zero match raises flag and timer start
  AST_MATCH0_FLAG: assert property (
    hit0 |=> st_q.flags[`LPTC_FLG_M0] && o_timer_start[0])
    else $error("match zero flag or start missing");

  // Channel one match raises flag and timer start
  AST_MATCH1_FLAG: assert property (
    hit1 |=> st_q.flags[`LPTC_FLG_M1] && o_timer_start[1])
    else $error("match one flag or start missing");

  // Interrupt tracks enabled flags
  AST_IRQ_LEVEL: assert property (
    o_irq == |(st_q.flags & st_q.ien))
    else $error("interrupt disagrees with flags");

  // Channel zero event pulse ends at the next tick without a match
  AST_PULSE_END: assert property (
    (o_match_pulse[0] && tick && !hit0) |=> !o_match_pulse[0])
    else $error("event pulse too long");

  // Control write raises busy until the next take-over
  AST_SYNC_BUSY: assert property (
    s_ctrl_write |=> st_q.pend[`LPTC_PND_CTRL])
    else $error("busy bit not raised");

  AST_SYNC_DONE: assert property (
    s_takeover ##0 (!do_wr || ({st_q.aw_addr[`LPTC_ADDR_W-1:2], `LPTC_WORD_LSB}
      != `LPTC_OFF_CTRL)) |=> !st_q.pend[`LPTC_PND_CTRL]
      && (st_q.ctrl_act == $past(st_q.ctrl_sh)))
    else $error("take-over did not retire busy");

endmodule : lptc_top

`default_nettype wire

// file: bench/lptc_top_test.sv
// Self-checking bench for the low power tick counter
`timescale 1ns/10ps
`default_nettype none
`include "lptc_params.svh"

module lptc_top_test;
  logic        clk = 1'b0;   // Bus clock
  logic        nrst;         // Reset, active low
  logic        lf;           // Tick pin
  logic        halt;         // Debugger halt
  logic        awv, wv, bdy; // Write handshakes driven
  logic        arv, rdy;     // Read handshakes driven
  logic [11:0] awa, ara;     // Addresses
  logic [31:0] wd, rd;       // Write and read data
  logic [3:0]  ws;           // Byte strobes
  logic        awrdy, wrdy, bv, arrdy, rv, irq; // Design answers
  logic [1:0]  br, rr, mp, ts; // Responses, event pulses, timer starts
  int          bad_count = 0;   // Mismatches
  int          check_count = 0; // Comparisons
  int          st0 = 0;      // Timer starts seen, channel 0
  int          st1 = 0;      // Timer starts seen, channel 1
  logic [31:0] v, c;         // Last read value, saved count
  logic [1:0]  resp;         // Last response

  lptc_top dut_u (.i_clock(clk), .i_nrst(nrst), .i_lf_tick(lf), .i_debug_halt(halt),
    .i_awvalid(awv), .o_awready(awrdy), .i_awaddr(awa), .i_wvalid(wv), .o_wready(wrdy),
    .i_wdata(wd), .i_wstrb(ws), .o_bvalid(bv), .i_bready(bdy), .o_bresp(br),
    .i_arvalid(arv), .o_arready(arrdy), .i_araddr(ara), .o_rvalid(rv), .i_rready(rdy),
    .o_rdata(rd), .o_rresp(rr), .o_irq(irq), .o_match_pulse(mp), .o_timer_start(ts));

  // Clock, 8 ns period
  initial begin
    forever #4 clk = ~clk;
  end

  // Count timer start pulses; each must be a single cycle per match
  always @(posedge clk) begin
    if (ts[0] === 1'b1) st0 <= st0 + 1;
    if (ts[1] === 1'b1) st1 <= st1 + 1;
  end

  // Compare one value and report a mismatch at once
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Write one word; address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    bdy <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awrdy === 1'b1) awv <= 1'b0;
      if (wrdy === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 100);
    resp = br;
    bdy <= 1'b0;
    if (n >= 100) chk("write answer", 32'h1, 32'h0);
    // Extra edge so no handshake signal is driven twice in one step
    @(posedge clk);
  endtask : wr

  // Read one word into v and resp
  task automatic rdt(input logic [11:0] a);
    int n;
    n = 0;
    arv <= 1'b1;
    ara <= a;
    rdy <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arrdy === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 100);
    v = rd;
    resp = rr;
    rdy <= 1'b0;
    if (n >= 100) chk("read answer", 32'h1, 32'h0);
    @(posedge clk);
  endtask : rdt

  // Read and compare
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string n);
    rdt(a);
    chk(n, e, v);
  endtask : rchk

  // One counter tick: pin high and low long enough for the synchroniser
  task automatic tick();
    lf <= 1'b1;
    repeat (10) @(posedge clk);
    lf <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : tick

  // Reset values, read-only count, unmapped place
  task automatic t_reset();
    rchk(`LPTC_OFF_CTRL, 32'h0, "control");
    rchk(`LPTC_OFF_CNT, 32'h0, "count");
    rchk(`LPTC_OFF_MATCH0, 32'h0, "match zero");
    rchk(`LPTC_OFF_MATCH1, 32'h0, "match one");
    rchk(`LPTC_OFF_FLAGS, 32'h0, "flags");
    rchk(`LPTC_OFF_IEN, 32'h0, "enables");
    rchk(`LPTC_OFF_PEND, 32'h0, "busy");
    wr(12'h028, 32'h1);
    chk("unmapped write resp", {30'h0, `LPTC_RESP_SLVERR}, {30'h0, resp});
    rdt(12'h028);
    chk("unmapped read resp", {30'h0, `LPTC_RESP_SLVERR}, {30'h0, resp});
    chk("unmapped read data", 32'h0, v);
    wr(`LPTC_OFF_CNT, 32'h55);
    rchk(`LPTC_OFF_CNT, 32'h0, "count after write");
  endtask : t_reset

  // Counting, busy bits across the crossing, hold, disable clears
  task automatic t_count();
    wr(`LPTC_OFF_MATCH1, 32'h2);
    wr(`LPTC_OFF_CTRL, 32'h1);
    rchk(`LPTC_OFF_PEND, 32'h5, "busy set");
    tick();
    rchk(`LPTC_OFF_PEND, 32'h0, "busy clear");
    rdt(`LPTC_OFF_CNT);
    c = v;
    repeat (3) tick();
    rchk(`LPTC_OFF_CNT, c + 32'h3, "count steps");
    wr(`LPTC_OFF_HOLD, 32'h1);
    wr(`LPTC_OFF_CTRL, 32'h0);
    tick();
    rchk(`LPTC_OFF_PEND, 32'h1, "busy held");
    wr(`LPTC_OFF_HOLD, 32'h0);
    tick();
    rchk(`LPTC_OFF_PEND, 32'h0, "busy released");
    rchk(`LPTC_OFF_CNT, 32'h0, "count disabled");
  endtask : t_count

  // Match zero as top, both channels, wrap flag, pulses
  task automatic t_top();
    int b0, b1;
    wr(`LPTC_OFF_MATCH0, 32'h3);
    wr(`LPTC_OFF_MATCH1, 32'h2);
    wr(`LPTC_OFF_CTRL, 32'h5);
    wr(`LPTC_OFF_FCLR, 32'h7);
    b0 = st0;
    b1 = st1;
    for (int i = 0; i < 6; i++) begin
      tick();
      rdt(`LPTC_OFF_CNT);
      if (v === 32'h3) break;
    end
    chk("count at top", 32'h3, v);
    chk("pulse ch1 held", 32'h1, {31'h0, mp[1]});
    rchk(`LPTC_OFF_FLAGS, 32'h4, "flags before top");
    tick();
    rchk(`LPTC_OFF_CNT, 32'h0, "count after top");
    rchk(`LPTC_OFF_FLAGS, 32'h7, "flags after top");
    chk("starts ch0", b0 + 1, st0);
    chk("starts ch1", b1 + 1, st1);
    chk("pulse ch0 held", 32'h1, {31'h0, mp[0]});
    chk("pulse ch1 ended", 32'h0, {31'h0, mp[1]});
    tick();
    chk("pulse ch0 ended", 32'h0, {31'h0, mp[0]});
    wr(`LPTC_OFF_CTRL, 32'h0);
    tick();
  endtask : t_top

  // Interrupt masked, enabled, cleared and set again
  task automatic t_irq();
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`LPTC_OFF_IEN, 32'h1);
    chk("irq enabled", 32'h1, {31'h0, irq});
    wr(`LPTC_OFF_FCLR, 32'h1);
    rchk(`LPTC_OFF_FLAGS, 32'h6, "flags cleared");
    chk("irq after clear", 32'h0, {31'h0, irq});
    wr(`LPTC_OFF_FSET, 32'h1);
    rchk(`LPTC_OFF_FLAGS, 32'h7, "flags set");
    chk("irq after set", 32'h1, {31'h0, irq});
    wr(`LPTC_OFF_FCLR, 32'h7);
    wr(`LPTC_OFF_IEN, 32'h0);
  endtask : t_irq

  // Halt freezes unless the run bit is set
  task automatic t_halt();
    wr(`LPTC_OFF_CTRL, 32'h1);
    tick();
    halt <= 1'b1;
    rdt(`LPTC_OFF_CNT);
    c = v;
    repeat (2) tick();
    rchk(`LPTC_OFF_CNT, c, "count frozen");
    wr(`LPTC_OFF_CTRL, 32'h3);
    tick();
    rdt(`LPTC_OFF_CNT);
    c = v;
    tick();
    rchk(`LPTC_OFF_CNT, c + 32'h1, "count runs");
    halt <= 1'b0;
    wr(`LPTC_OFF_CTRL, 32'h0);
  endtask : t_halt

  // Counts, verdict, end of run
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    nrst = 1'b0;
    lf = 1'b0;
    halt = 1'b0;
    {awv, wv, bdy, arv, rdy} = 5'h0;
    awa = 12'h0;
    ara = 12'h0;
    wd = 32'h0;
    ws = 4'hf;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_count();
    t_top();
    t_irq();
    t_halt();
    end_of_test();
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    chk("watchdog", 32'h0, 32'h1);
    end_of_test();
  end
endmodule : lptc_top_test
`default_nettype wire
